/* hdl/ebw_bus_ctrl.sv */
// Purpose: External bus sequencer with bank selects, wait states, posted write and float
// Assumes: core holds its request until core_ready; pins outside pclk pass four flops
// Notes: Output enables and keeper gate asynchronously on output_float_n
//
// Notes on behaviour
// - On reset, end or abandon an external access within 10 cycles, pins idle.
// - Reset with float low abandons at once, all bus pins high-impedance.
// - Float low disables every output asynchronously, clock or not.
// - Four bank selects from address bits 23:22 and strobe, strobe timing.
// - Each bank select active only for external accesses in its quarter.
// - All external accesses take wait and ready setup from one register.
// - Combined ready sampled on the rising clock edge.
// - Bits 4:3 pick pin, counter, AND or OR; OR after reset.
// - AND mode: ready low means zero waits, high leaves counter in charge.
// - OR mode: never shorter than wait count, stretched while ready high.
// - Bank compare adds one null cycle before reads to another bank.
// - Writes posted in one buffer; core stalls only on a further access.
// - Data keepers on in all modes, off only while float is low.
// - Boot mode maps internal ROM at 0x000000-0x000FFF, no external activity.
`timescale 1ns/1ps
module ebw_bus_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ebw_pkg::PADDR_W-1:0] paddr,
  input wire logic [ebw_pkg::DATA_W-1:0] pwdata,
  output logic [ebw_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ebw_pkg::ebw_core_req_type core_req,
  output logic core_ready,
  output logic [ebw_pkg::DATA_W-1:0] core_rdata,
  output logic boot_rom_sel,
  input wire logic cpu_reset_n,
  input wire logic output_float_n,
  input wire logic boot_mode_select,
  input wire logic ext_ready_n,
  input wire logic [ebw_pkg::DATA_W-1:0] data_in,
  output ebw_pkg::ebw_bus_pins_type bus_pins,
  output logic addr_oe,
  output logic data_oe,
  output logic ctrl_oe,
  output logic keeper_en
);
  import ebw_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] sync3_ff;
  logic [SYNC_W-1:0] stable_ff;
  logic [SYNC_W-1:0] nxt_stable;
  logic rst_sync;
  logic float_sync;
  logic boot_sync;
  logic rdy_n_sync;

  logic [31:0] bus_ctrl_ff;
  logic [31:0] nxt_bus_ctrl;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] status;

  ebw_state_type state_ff;
  ebw_state_type nxt_state;
  ebw_bus_pins_type pins_ff;
  ebw_bus_pins_type nxt_pins;
  logic own_ff;
  logic nxt_own;
  logic drv_ff;
  logic nxt_drv;
  logic wr_ff;
  logic nxt_wr;
  logic [1:0] last_bank_ff;
  logic [1:0] nxt_last_bank;
  logic [3:0] drain_ff;
  logic [3:0] nxt_drain;
  logic rd_done_ff;
  logic nxt_rd_done;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic idle_ok;
  logic rom_now;
  logic wr_accept;
  logic rd_start;
  logic bank_compare_field_en;
  logic wait_start;
  logic wait_done;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_comb begin
    nxt_stable = stable_ff;
    for (int i = 0; i < SYNC_W; i++) begin
      if (sync2_ff[i] == sync3_ff[i]) begin
        nxt_stable[i] = sync3_ff[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= SYNC_RESET;
      sync2_ff <= SYNC_RESET;
      sync3_ff <= SYNC_RESET;
      stable_ff <= SYNC_RESET;
    end else if (clk_en) begin
      sync1_ff <= {output_float_n, boot_mode_select, cpu_reset_n, ext_ready_n};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign rst_sync = !stable_ff[SYNC_RST];
  assign float_sync = !stable_ff[SYNC_FLOAT];
  assign boot_sync = stable_ff[SYNC_BOOT];
  assign rdy_n_sync = stable_ff[SYNC_RDY];

  // ****************************************************************
  // APB registers
  // ****************************************************************
  assign status = {24'h000000, !float_sync, rst_sync, boot_sync, last_bank_ff, wr_ff && own_ff,
    state_ff};

  always_comb begin
    nxt_bus_ctrl = bus_ctrl_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (psel && !penable) begin
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h00000000;
      if (paddr == OFF_BUS_CTRL) begin
        nxt_prdata = bus_ctrl_ff;
      end else if (paddr == OFF_STATUS) begin
        nxt_prdata = status;
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
    if (psel && penable && pwrite && paddr == OFF_BUS_CTRL) begin
      nxt_bus_ctrl = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ctrl_ff <= BUS_CTRL_RESET;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      bus_ctrl_ff <= nxt_bus_ctrl;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff && psel && penable;
  assign bank_compare_field_en = bus_ctrl_ff[BANK_COMPARE_FIELD_BIT];

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  assign idle_ok = (state_ff == ST_IDLE) && !rst_sync && !rd_done_ff;
  assign rom_now = idle_ok && core_req.valid && in_boot_rom(boot_sync, core_req.addr);
  assign wr_accept = idle_ok && core_req.valid && core_req.write && !rom_now;
  assign rd_start = idle_ok && core_req.valid && !core_req.write && !rom_now;

  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    nxt_wr = wr_ff;
    nxt_last_bank = last_bank_ff;
    nxt_drain = 4'h0;
    nxt_rd_done = 1'b0;
    nxt_rdata = rdata_ff;
    case (state_ff)
      ST_IDLE: begin
        if (wr_accept || rd_start) begin
          nxt_pins.addr = core_req.addr;
          nxt_pins.data = core_req.wdata;
          nxt_wr = core_req.write;
          nxt_last_bank = bank_of(core_req.addr);
          if (rd_start && bank_compare_field_en && bank_of(core_req.addr) != last_bank_ff) begin
            nxt_state = ST_NULL;
          end else begin
            nxt_state = ST_ACCESS;
          end
        end
      end
      ST_NULL: begin
        if (rst_sync) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (rst_sync) begin
          nxt_drain = drain_ff + 4'h1;
        end
        if (rst_sync && float_sync) begin
          nxt_state = ST_IDLE;
        end else if (wait_done) begin
          nxt_state = ST_IDLE;
          nxt_rd_done = !wr_ff && !rst_sync;
          if (!wr_ff) begin
            nxt_rdata = data_in;
          end
        end else if (rst_sync && drain_ff == DRAIN_CYCLES - 4'h1) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_pins.rw = !nxt_wr;
    nxt_pins.external_strobe_n = (nxt_state != ST_ACCESS);
    nxt_pins.bank_select_n = 4'hF;
    if (nxt_state == ST_ACCESS) begin
      nxt_pins.bank_select_n = ~(4'h1 << bank_of(nxt_pins.addr));
    end
    nxt_own = (nxt_state != ST_IDLE);
    nxt_drv = (nxt_state != ST_IDLE) && nxt_wr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      pins_ff <= '{addr: 24'h000000, data: 32'h00000000, external_strobe_n: 1'b1,
        rw: 1'b1, bank_select_n: 4'hF};
      own_ff <= 1'b0;
      drv_ff <= 1'b0;
      wr_ff <= 1'b0;
      last_bank_ff <= 2'h0;
      drain_ff <= 4'h0;
      rd_done_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      own_ff <= nxt_own;
      drv_ff <= nxt_drv;
      wr_ff <= nxt_wr;
      last_bank_ff <= nxt_last_bank;
      drain_ff <= nxt_drain;
      rd_done_ff <= nxt_rd_done;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Wait generator
  // ****************************************************************
  assign wait_start = (nxt_state == ST_ACCESS) && (state_ff != ST_ACCESS);

  ebw_wait_gen u_wait (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .start(wait_start),
    .active(state_ff == ST_ACCESS),
    .wait_count(bus_ctrl_ff[WAIT_COUNT_FIELD_LSB+WAIT_COUNT_FIELD_W-1:WAIT_COUNT_FIELD_LSB]),
    .mux(ebw_rdy_mux_type'(bus_ctrl_ff[MUX_LSB+1:MUX_LSB])),
    .ext_ready_n(rdy_n_sync),
    .done(wait_done)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign core_ready = rd_done_ff || wr_accept || rom_now;
  assign core_rdata = rdata_ff;
  assign boot_rom_sel = rom_now;
  assign bus_pins = pins_ff;
  assign addr_oe = own_ff && output_float_n;
  assign data_oe = drv_ff && output_float_n;
  assign ctrl_oe = output_float_n;
  assign keeper_en = output_float_n;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !clk_en);

  AST_BANK_STROBE: assert property (!pins_ff.external_strobe_n
    == ($countones(~pins_ff.bank_select_n) == 1))
    else $error("bank select out of step with strobe");
  AST_BANK_RANGE: assert property (!pins_ff.external_strobe_n
    |-> !pins_ff.bank_select_n[bank_of(pins_ff.addr)])
    else $error("wrong bank select for address");
  AST_RESET_DRAIN: assert property (rst_sync && state_ff == ST_ACCESS
    |-> ##[1:10] state_ff == ST_IDLE)
    else $error("access not ended within 10 cycles of reset");
  AST_FLOAT_RESET: assert property (rst_sync && float_sync |=> state_ff == ST_IDLE)
    else $error("reset with float did not abandon at once");
  AST_FLOAT_OFF: assert property (!output_float_n
    |-> !addr_oe && !data_oe && !ctrl_oe && !keeper_en)
    else $error("outputs enabled while float low");
  AST_KEEPER_ON: assert property (output_float_n |-> keeper_en)
    else $error("keeper off in functional mode");
  AST_NULL_READ: assert property (state_ff == ST_NULL |-> !wr_ff ##1 (state_ff == ST_ACCESS
    || $past(rst_sync)))
    else $error("null cycle on a write or not followed by access");
  AST_ROM_QUIET: assert property (boot_rom_sel |=> pins_ff.external_strobe_n && !own_ff)
    else $error("bus activity on boot ROM access");
  AST_POSTED: assert property (wr_accept |=> state_ff == ST_ACCESS && drv_ff && wr_ff)
    else $error("posted write not put on bus");

  COV_WRITE: cover property (wr_accept ##1 !pins_ff.external_strobe_n);
  COV_NULL_READ: cover property (state_ff == ST_NULL ##1 state_ff == ST_ACCESS);
  COV_DRAIN: cover property (rst_sync && state_ff == ST_ACCESS ##1 state_ff == ST_ACCESS);
  COV_ROM: cover property (boot_rom_sel);

endmodule // ebw_bus_ctrl

/* common/ebw_pkg.sv */
// Purpose: Shared constants, types and helpers of the external bus wait and bank decode block
// Assumes: 24-bit external address, 32-bit data, APB register access
// Notes: All offsets, field positions, reset values and counts live here
package ebw_pkg;

  // ****************************************************************
  // Widths and register map
  // ****************************************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int PADDR_W = 12;
  localparam logic [11:0] OFF_BUS_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;

  // ****************************************************************
  // Bus control fields and reset value
  // ****************************************************************
  localparam int MUX_LSB = 3;
  localparam int WAIT_COUNT_FIELD_LSB = 5;
  localparam int WAIT_COUNT_FIELD_W = 3;
  localparam int BANK_COMPARE_FIELD_BIT = 12;
  localparam logic [31:0] BUS_CTRL_RESET = 32'h000000F8;

  // ****************************************************************
  // Status fields
  // ****************************************************************
  localparam int ST_STATE_LSB = 0;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_BANK_LSB = 3;
  localparam int ST_BOOT_BIT = 5;
  localparam int ST_RST_BIT = 6;
  localparam int ST_FLOAT_BIT = 7;

  // ****************************************************************
  // Counts, address ranges, synchroniser layout
  // ****************************************************************
  localparam logic [3:0] DRAIN_CYCLES = 4'hA;
  localparam logic [23:0] ROM_LAST = 24'h000FFF;
  localparam int BANK_LSB = 22;
  localparam int SYNC_W = 4;
  localparam int SYNC_FLOAT = 3;
  localparam int SYNC_BOOT = 2;
  localparam int SYNC_RST = 1;
  localparam int SYNC_RDY = 0;
  localparam logic [3:0] SYNC_RESET = 4'h9;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MUX_EXT = 2'h0,
    MUX_INT = 2'h1,
    MUX_AND = 2'h2,
    MUX_OR = 2'h3
  } ebw_rdy_mux_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_NULL = 2'h1,
    ST_ACCESS = 2'h3
  } ebw_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [31:0] wdata;
  } ebw_core_req_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] data;
    logic external_strobe_n;
    logic rw;
    logic [3:0] bank_select_n;
  } ebw_bus_pins_type;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [1:0] bank_of(input logic [23:0] a);
    return a[BANK_LSB+1:BANK_LSB];
  endfunction

  function automatic logic in_boot_rom(input logic boot, input logic [23:0] a);
    return boot && (a <= ROM_LAST);
  endfunction

endpackage

/* hdl/ebw_wait_gen.sv */
// Purpose: Wait counter and ready source combining for one external access
// Assumes: ext_ready_n already synchronised, start pulses on entry to an access
// Notes: done is combinational and only meaningful during an access
`timescale 1ns/1ps
module ebw_wait_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic active,
  input wire logic [ebw_pkg::WAIT_COUNT_FIELD_W-1:0] wait_count,
  input wire ebw_pkg::ebw_rdy_mux_type mux,
  input wire logic ext_ready_n,
  output logic done
);
  import ebw_pkg::*;

  logic [WAIT_COUNT_FIELD_W-1:0] cnt_ff;
  logic [WAIT_COUNT_FIELD_W-1:0] nxt_cnt;
  logic int_rdy;
  logic ext_rdy;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = wait_count;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************************************
  // Ready combining
  // ****************************************************************
  assign int_rdy = (cnt_ff == '0);
  assign ext_rdy = !ext_ready_n;

  always_comb begin
    case (mux)
      MUX_EXT: done = ext_rdy;
      MUX_INT: done = int_rdy;
      MUX_AND: done = ext_rdy || int_rdy;
      default: done = ext_rdy && int_rdy;
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !clk_en);

  AST_WAIT_LOAD: assert property (start |=> cnt_ff == $past(wait_count))
    else $error("wait counter not loaded at access start");
  AST_AND_ZERO: assert property (active && mux == MUX_AND && !ext_ready_n |-> done)
    else $error("AND mode did not finish with ready low");
  AST_OR_MIN: assert property (active && mux == MUX_OR && (ext_ready_n || cnt_ff != '0)
    |-> !done)
    else $error("OR mode finished early");

endmodule // ebw_wait_gen

/* test/ebw_ext_mem.sv */
// Purpose: External memory model on the parallel bus
// Assumes: Strobe low marks an access, rw high reads
// Notes: Ready held off for hold cycles of each access
`timescale 1ns/1ps
module ebw_ext_mem (
  input wire logic pclk,
  input wire ebw_pkg::ebw_bus_pins_type pins,
  input wire logic keeper_en,
  input wire logic [7:0] hold,
  output logic [31:0] data_in,
  output logic ext_ready_n
);
  import ebw_pkg::*;
  // ****************************************************************
  // Storage, ready and data bus level
  // ****************************************************************
  logic [31:0] mem [16];
  logic [31:0] last = 32'h0;
  logic [7:0] cnt = 8'h0;
  logic rd_drv;
  assign rd_drv = !pins.external_strobe_n && pins.rw;
  always @(posedge pclk) begin
    cnt <= pins.external_strobe_n ? 8'h0 : cnt + 8'h1;
    if (!pins.external_strobe_n && !pins.rw) begin
      mem[pins.addr[3:0]] <= pins.data;
      last <= pins.data;
    end
    if (rd_drv) begin
      last <= mem[pins.addr[3:0]];
    end
  end
  assign ext_ready_n = (cnt < hold);
  // Undriven bus keeps last value only while keepers are on
  always_comb begin
    if (rd_drv) begin
      data_in = mem[pins.addr[3:0]];
    end else if (keeper_en) begin
      data_in = last;
    end else begin
      data_in = ~last;
    end
  end
endmodule // ebw_ext_mem

/* test/tb.sv */
// Purpose: Self-checking bench of the external bus sequencer
// Assumes: APB slave answers with pready, memory model on far side
// Notes: One task per scenario
`timescale 1ns/1ps
module tb;
  import ebw_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, core_ready;
  logic boot_rom_sel, cpu_reset_n, output_float_n, boot_mode_select, ext_ready_n;
  logic addr_oe, data_oe, ctrl_oe, keeper_en, err, rom;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, core_rdata, data_in, rd;
  logic [7:0] hold;
  ebw_core_req_type core_req;
  ebw_bus_pins_type bus_pins;
  int n_fail = 0;
  int checks = 0;
  int len, start, rdy_at;
  ebw_bus_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_req(core_req), .core_ready(core_ready),
    .core_rdata(core_rdata), .boot_rom_sel(boot_rom_sel), .cpu_reset_n(cpu_reset_n),
    .output_float_n(output_float_n), .boot_mode_select(boot_mode_select),
    .ext_ready_n(ext_ready_n), .data_in(data_in), .bus_pins(bus_pins), .addr_oe(addr_oe),
    .data_oe(data_oe), .ctrl_oe(ctrl_oe), .keeper_en(keeper_en));
  ebw_ext_mem mem_model (.pclk(pclk), .pins(bus_pins), .keeper_en(keeper_en), .hold(hold),
    .data_in(data_in), .ext_ready_n(ext_ready_n));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      n_fail++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) begin n_fail++; end_of_test(); end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_ctrl(input logic [1:0] mx, input logic [2:0] w, input logic bc);
    logic [31:0] v;
    v = {19'h0, bc, 4'h0, w, mx, 3'h0};
    apb(1'b1, OFF_BUS_CTRL, v);
    apb(1'b0, OFF_BUS_CTRL, 32'h0);
    chk("bus_ctrl", v, rd);
  endtask
  task automatic access(input logic wr, input logic [23:0] a, input logic [31:0] d,
      input logic ext, input logic full);
    int n;
    logic got;
    n = 0; got = 0; len = 0; start = 0; rdy_at = 0; rom = 0;
    @(posedge pclk);
    core_req <= '{1'b1, wr, a, d};
    while (!(got && (!full || (bus_pins.external_strobe_n && (len > 0 || !ext))))) begin
      @(posedge pclk);
      n++;
      if (n > 400) begin n_fail++; end_of_test(); end
      if (core_ready === 1'b1 && !got) begin
        got = 1; rdy_at = n; rd = core_rdata; rom = boot_rom_sel;
        core_req <= '0;
      end
      if (bus_pins.external_strobe_n === 1'b0) begin
        if (len == 0) start = n;
        len++;
        chk("bank_sel", {28'h0, ~(4'h1 << a[23:22])}, {28'h0, bus_pins.bank_select_n});
        chk("addr", {8'h0, a}, {8'h0, bus_pins.addr});
        if (got && wr) begin
          chk("wdata", d, bus_pins.data);
          chk("wr_drive", 32'h1, {30'h0, bus_pins.rw, data_oe});
        end
      end else begin
        chk("bank_idle", 32'hF, {28'h0, bus_pins.bank_select_n});
      end
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_apb();
    apb(1'b0, OFF_BUS_CTRL, 32'h0);
    chk("ctrl_reset", BUS_CTRL_RESET, rd);
    apb(1'b1, 12'h008, 32'h5);
    chk("unmapped_wr", 32'h1, {31'h0, err});
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_rd", 32'h1, {31'h0, err});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h00000001 << ST_FLOAT_BIT, rd);
    clk_en <= 1'b0;
    apb(1'b1, OFF_BUS_CTRL, 32'h0);
    clk_en <= 1'b1;
    apb(1'b0, OFF_BUS_CTRL, 32'h0);
    chk("ctrl_frozen", BUS_CTRL_RESET, rd);
  endtask
  task automatic t_modes();
    logic [1:0] mx [7] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0};
    logic [2:0] w [7] = '{3'h2, 3'h7, 3'h2, 3'h3, 3'h1, 3'h7, 3'h0};
    logic [7:0] hv [7] = '{8'h28, 8'h0, 8'h28, 8'h0, 8'h8, 8'h0, 8'h5};
    int ev [7] = '{3, 1, 3, 4, 8, 1, 5};
    logic exact [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      hold <= hv[i];
      set_ctrl(mx[i], w[i], 1'b0);
      repeat (5) @(posedge pclk);
      access(1'b1, 24'h000005, 32'h11110000 + i, 1'b1, 1'b1);
      if (exact[i]) begin
        chk("strobe_len", 32'(ev[i]), 32'(len));
      end else begin
        chk("strobe_stretch", 32'h1, {31'h0, len > ev[i]});
      end
    end
    hold <= 8'h0;
  endtask
  task automatic t_banks();
    int ws, rs;
    set_ctrl(2'h1, 3'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      access(1'b1, {2'(i), 18'h0, 4'(i + 1)}, 32'hA5A50000 + i, 1'b1, 1'b1);
      if (i == 0) ws = start;
      chk("write_start", 32'(ws), 32'(start));
    end
    access(1'b0, {2'h3, 18'h0, 4'h4}, 32'h0, 1'b1, 1'b1);
    rs = start;
    chk("read_b3", 32'hA5A50003, rd);
    for (int i = 0; i < 3; i++) begin
      access(1'b0, {2'(i), 18'h0, 4'(i + 1)}, 32'h0, 1'b1, 1'b1);
      chk("null_cycle", 32'(rs + 1), 32'(start));
      chk("read_data", 32'hA5A50000 + i, rd);
    end
  endtask
  task automatic t_post();
    set_ctrl(2'h1, 3'h5, 1'b0);
    access(1'b1, 24'h000007, 32'hC0DE0001, 1'b1, 1'b0);
    chk("posted_ready", 32'h1, 32'(rdy_at));
    access(1'b1, 24'h000007, 32'hC0DE0002, 1'b1, 1'b1);
    chk("second_stall", 32'h1, {31'h0, rdy_at > 5});
    access(1'b0, 24'h000007, 32'h0, 1'b1, 1'b1);
    chk("posted_data", 32'hC0DE0002, rd);
  endtask
  task automatic t_boot();
    boot_mode_select <= 1'b1;
    repeat (6) @(posedge pclk);
    access(1'b0, 24'h000100, 32'h0, 1'b0, 1'b1);
    chk("rom_hit", 32'h1, {31'h0, rom});
    chk("rom_no_bus", 32'h0, 32'(len));
    access(1'b0, 24'h001005, 32'h0, 1'b1, 1'b1);
    chk("above_rom", 32'h0, {31'h0, rom});
    boot_mode_select <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (bus_pins.external_strobe_n !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin n_fail++; end_of_test(); end
    end
    chk("pins_idle", 32'h0, {30'h0, addr_oe, data_oe});
  endtask
  task automatic t_reset();
    hold <= 8'hC8;
    set_ctrl(2'h0, 3'h0, 1'b0);
    repeat (5) @(posedge pclk);
    access(1'b1, 24'h000009, 32'h0, 1'b1, 1'b0);
    repeat (2) @(posedge pclk);
    cpu_reset_n <= 1'b0;
    wait_idle(18);
    cpu_reset_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_float();
    access(1'b1, 24'h000009, 32'h0, 1'b1, 1'b0);
    repeat (2) @(posedge pclk);
    output_float_n <= 1'b0;
    cpu_reset_n <= 1'b0;
    #1;
    chk("float_oe", 32'h0, {28'h0, addr_oe, data_oe, ctrl_oe, keeper_en});
    wait_idle(8);
    @(posedge pclk);
    output_float_n <= 1'b1;
    repeat (12) @(posedge pclk);
    cpu_reset_n <= 1'b1;
    hold <= 8'h0;
    repeat (8) @(posedge pclk);
    chk("keeper_on", 32'h1, {31'h0, keeper_en});
  endtask
  // ****************************************************************
  // Clock, reset and main sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; core_req = '0; cpu_reset_n = 1'b1;
    output_float_n = 1'b1; boot_mode_select = 1'b0; hold = 8'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_apb();
    t_modes();
    t_banks();
    t_post();
    t_boot();
    t_reset();
    t_float();
    end_of_test();
  end
endmodule // tb
